// [ffpr_pkg.sv]
// Purpose: Shared constants for the fault and PWM/indicator register bank
// Assumes: 50 MHz system clock, 8-bit register bus from the serial slave
// Notes:   Every offset, field position and timing count lives here
`default_nettype none

package ffpr_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_FAULT = 8'h08;
  localparam logic [7:0] ADDR_PWM   = 8'h09;

  // Fault register fields
  localparam int FLT_UVLO     = 0;
  localparam int FLT_TXMASK   = 3;
  localparam int FLT_TIMEOUT  = 4;
  localparam int FLT_OVERTEMP = 5;
  localparam int FLT_SHORT    = 6;
  localparam int FLT_OVP      = 7;
  localparam logic [7:0] FAULT_RESET = 8'h00;

  // PWM and indicator register fields
  localparam int PWM_DUTY_LSB   = 0;
  localparam int PWM_DUTY_MSB   = 1;
  localparam int PWM_FIXFREQ    = 2;
  localparam int PWM_ONE_HIGHER = 3;
  localparam int PWM_TWO_HIGHER = 4;
  localparam logic [1:0] DUTY_RESET    = 2'h0;
  localparam logic       FIXFREQ_RESET = 1'b0;

  // Operating mode codes
  localparam logic [1:0] MODE_INDICATOR = 2'h1;
  localparam logic [1:0] MODE_ASSIST    = 2'h2;
  localparam logic [1:0] MODE_FLASH     = 2'h3;

  // Least sink code for fixed-frequency running
  localparam logic [7:0] CUR_FIXFREQ_MIN = 8'h40;

  // PWM timing
  localparam int CLK_HZ         = 50_000_000;
  localparam int PWM_FREQ_HZ    = 31_250;
  localparam int PWM_SLOTS      = 16;
  localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;
  localparam int SLOT_CYC       = PWM_PERIOD_CYC / PWM_SLOTS;
  localparam int SLOT_CNT_W     = $clog2(SLOT_CYC);
  localparam int SLOT_IDX_W     = $clog2(PWM_SLOTS);
  localparam logic [SLOT_CNT_W-1:0] SLOT_LAST = SLOT_CNT_W'(SLOT_CYC - 1);
  localparam logic [SLOT_IDX_W-1:0] IDX_LAST  = SLOT_IDX_W'(PWM_SLOTS - 1);

endpackage : ffpr_pkg

`default_nettype wire

// [ffpr_pwm_if.sv]
// Purpose: Carries duty select, run request and gate between control and PWM
// Assumes: Same clock on both sides
// Notes:   No clocking block; plain modports
`default_nettype none

interface ffpr_pwm_if;
  logic [1:0] duty;
  logic       run;
  logic       gate;
  logic       periodEnd;

  modport ctrl (output duty, output run, input gate, input periodEnd);
  modport gen  (input duty, input run, output gate, output periodEnd);
endinterface : ffpr_pwm_if

`default_nettype wire

// [ffpr_sync.sv]
// Purpose: Two-flop synchroniser for pin-level inputs
// Assumes: Inputs are slow levels from analog detectors
// Notes:   First stage is read by the second stage only
`default_nettype none

module ffpr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] stage1;

  // Metastability guard
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      stage1 <= '0;
      q      <= '0;
    end
    else
    begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule // ffpr_sync

`default_nettype wire

// [ffpr_pwm.sv]
// Purpose: 31.25 kHz indicator PWM with duty of (code+1)/16
// Assumes: 50 MHz clock; slot pulse from a divider
// Notes:   Gate is registered, so it goes low the cycle after run goes low
`default_nettype none

module ffpr_pwm (
  input  wire logic clk_sys,
  input  wire logic reset,
  ffpr_pwm_if.gen   pwm
);

  logic [ffpr_pkg::SLOT_CNT_W-1:0] slotCnt;
  logic [ffpr_pkg::SLOT_IDX_W-1:0] slotIdx;
  logic                            slotTick;
  logic                            next_gate;

  // Divider enable, one pulse per sixteenth of the period
  assign slotTick  = (slotCnt == ffpr_pkg::SLOT_LAST);
  // Slot index below code+1 gives 1/16..4/16
  assign next_gate = pwm.run && (slotIdx <= {2'h0, pwm.duty});

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      slotCnt       <= '0;
      slotIdx       <= '0;
      pwm.gate      <= 1'b0;
      pwm.periodEnd <= 1'b0;
    end
    else
    begin
      slotCnt       <= slotTick ? '0 : slotCnt + 1'b1;
      slotIdx       <= slotTick ? slotIdx + 1'b1 : slotIdx;
      pwm.gate      <= next_gate;
      pwm.periodEnd <= slotTick && (slotIdx == ffpr_pkg::IDX_LAST);
    end
  end

  // Helper: high cycles per full period while running
  logic [11:0] highCnt;
  logic        runWhole;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      highCnt  <= '0;
      runWhole <= 1'b0;
    end
    else if (pwm.periodEnd)
    begin
      // Run level of the period's first cycle is only seen here
      highCnt  <= '0;
      runWhole <= pwm.run;
    end
    else
    begin
      highCnt  <= highCnt + {11'h0, pwm.gate};
      runWhole <= runWhole && pwm.run && $stable(pwm.duty);
    end
  end

  property p_duty;
    @(posedge clk_sys) disable iff (reset)
    (pwm.periodEnd && runWhole && pwm.run)
      |-> (highCnt == 12'((pwm.duty + 1) * ffpr_pkg::SLOT_CYC));
  endproperty
  a_duty: assert property (p_duty) else $error("PWM high time wrong");

  property p_period;
    @(posedge clk_sys) disable iff (reset)
    pwm.periodEnd |=> !pwm.periodEnd [*8];
  endproperty
  a_period: assert property (p_period) else $error("PWM period too short");

endmodule // ffpr_pwm

`default_nettype wire

// [ffpr_regs.sv]
// Purpose: Fault register (read-clear flags) and PWM/indicator register
// Assumes: Register strobes come from the serial bus slave on clk_sys;
//          detector and comparator inputs are asynchronous levels
// Notes:   Read data is registered and valid the cycle after regRead
`default_nettype none

module ffpr_regs (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output var  logic [7:0] regRdData,
  input  wire logic       overtempDetect,
  input  wire logic       ledShortDetect,
  input  wire logic       ovpDetect,
  input  wire logic       uvloDetect,
  input  wire logic       txmaskDetect,
  input  wire logic       timeoutDetect,
  input  wire logic       sinkOneHigherCmp,
  input  wire logic       sinkTwoHigherCmp,
  input  wire logic       converterActive,
  input  wire logic [1:0] modeSetting,
  input  wire logic [7:0] sinkOneCurrentCode,
  input  wire logic [7:0] sinkTwoCurrentCode,
  input  wire logic       currentBoost,
  output var  logic       sinkPwmGate,
  output var  logic       fixedFreqRun,
  output var  logic       pulseSkipAllowed
);

  // Address match, used for reads and writes alike
  function automatic logic isAddr(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction

  logic [7:0] faultFlags;
  logic [7:0] faultSet;
  logic [7:0] faultClr;
  logic [7:0] next_faultFlags;
  logic [1:0] dutySelect;
  logic       fixFreqEn;
  logic       sinkOneHigherFlag;
  logic       sinkTwoHigherFlag;
  logic [5:0] detSync;
  logic [1:0] cmpSync;
  logic [7:0] pwmRegView;
  logic [7:0] next_rdData;
  logic       rdFault;
  logic       wrPwm;
  logic       fixQualified;
  logic       next_fixedFreqRun;

  ffpr_pwm_if pwmBus ();

  // Detector pins are asynchronous to the bus clock
  ffpr_sync #(.W(6)) u_detSync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .d       ({ovpDetect, ledShortDetect, overtempDetect,
                timeoutDetect, txmaskDetect, uvloDetect}),
    .q       (detSync)
  );

  // Comparator outputs likewise
  ffpr_sync #(.W(2)) u_cmpSync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .d       ({sinkTwoHigherCmp, sinkOneHigherCmp}),
    .q       (cmpSync)
  );

  ffpr_pwm u_pwm (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pwm     (pwmBus.gen)
  );

  // Strobe decode
  assign rdFault = regRead && isAddr(regAddr, ffpr_pkg::ADDR_FAULT);
  assign wrPwm   = regWrite && isAddr(regAddr, ffpr_pkg::ADDR_PWM);

  // Set vector from synchronised detectors; bits 1 and 2 stay zero
  always_comb
  begin
    faultSet = 8'h00;
    faultSet[ffpr_pkg::FLT_UVLO]     = detSync[0];
    faultSet[ffpr_pkg::FLT_TXMASK]   = detSync[1];
    faultSet[ffpr_pkg::FLT_TIMEOUT]  = detSync[2];
    faultSet[ffpr_pkg::FLT_OVERTEMP] = detSync[3];
    faultSet[ffpr_pkg::FLT_SHORT]    = detSync[4];
    faultSet[ffpr_pkg::FLT_OVP]      = detSync[5];
  end

  // Whole register clears on its read; writes never reach it
  assign faultClr = rdFault ? 8'hFF : 8'h00;

  // Set wins over the clear so an event in the read cycle is kept
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_flag
      assign next_faultFlags[gi] = faultSet[gi] | (faultFlags[gi] & ~faultClr[gi]);
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      faultFlags <= ffpr_pkg::FAULT_RESET;
    else
      faultFlags <= next_faultFlags;
  end

  // Writable PWM fields; read-only bits 3 and 4 ignore the write
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      dutySelect <= ffpr_pkg::DUTY_RESET;
      fixFreqEn  <= ffpr_pkg::FIXFREQ_RESET;
    end
    else if (wrPwm)
    begin
      dutySelect <= regWrData[ffpr_pkg::PWM_DUTY_MSB:ffpr_pkg::PWM_DUTY_LSB];
      fixFreqEn  <= regWrData[ffpr_pkg::PWM_FIXFREQ];
    end
  end

  // Comparator result only meaningful while converting; hold otherwise
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sinkOneHigherFlag <= 1'b0;
      sinkTwoHigherFlag <= 1'b0;
    end
    else if (converterActive)
    begin
      sinkOneHigherFlag <= cmpSync[0];
      sinkTwoHigherFlag <= cmpSync[1];
    end
  end

  // Register view and read mux; unmapped offsets read zero
  always_comb
  begin
    pwmRegView = 8'h00;
    pwmRegView[ffpr_pkg::PWM_DUTY_MSB:ffpr_pkg::PWM_DUTY_LSB] = dutySelect;
    pwmRegView[ffpr_pkg::PWM_FIXFREQ]    = fixFreqEn;
    pwmRegView[ffpr_pkg::PWM_ONE_HIGHER] = sinkOneHigherFlag;
    pwmRegView[ffpr_pkg::PWM_TWO_HIGHER] = sinkTwoHigherFlag;
  end

  assign next_rdData = isAddr(regAddr, ffpr_pkg::ADDR_FAULT) ? faultFlags :
                       isAddr(regAddr, ffpr_pkg::ADDR_PWM)   ? pwmRegView : 8'h00;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      regRdData <= 8'h00;
    else if (regRead)
      regRdData <= next_rdData;
  end

  // Indicator PWM request to the generator
  assign pwmBus.duty = dutySelect;
  assign pwmBus.run  = (modeSetting == ffpr_pkg::MODE_INDICATOR);

  // Fixed frequency only in flash/assist with strong sinks and no boost;
  // indicator mode never qualifies, so it always skips pulses
  assign fixQualified = ((modeSetting == ffpr_pkg::MODE_FLASH) ||
                         (modeSetting == ffpr_pkg::MODE_ASSIST)) &&
                        (sinkOneCurrentCode >= ffpr_pkg::CUR_FIXFREQ_MIN) &&
                        (sinkTwoCurrentCode >= ffpr_pkg::CUR_FIXFREQ_MIN) &&
                        !currentBoost;
  assign next_fixedFreqRun = fixFreqEn && fixQualified;

  // Outputs straight from flops
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      fixedFreqRun     <= 1'b0;
      pulseSkipAllowed <= 1'b1;
      sinkPwmGate      <= 1'b0;
    end
    else
    begin
      fixedFreqRun     <= next_fixedFreqRun;
      pulseSkipAllowed <= !next_fixedFreqRun;
      sinkPwmGate      <= pwmBus.gate;
    end
  end

  // Checks

  sequence s_faultRead;
    rdFault && !detSync[5];
  endsequence

  property p_ovpSet;
    @(posedge clk_sys) disable iff (reset)
    detSync[5] |=> faultFlags[ffpr_pkg::FLT_OVP];
  endproperty
  a_ovpSet: assert property (p_ovpSet) else $error("OVP flag not set");

  property p_tempSet;
    @(posedge clk_sys) disable iff (reset)
    $rose(detSync[3]) |=> faultFlags[ffpr_pkg::FLT_OVERTEMP] ##1 1'b1;
  endproperty
  a_tempSet: assert property (p_tempSet) else $error("Overtemp flag not set");

  property p_shortSet;
    @(posedge clk_sys) disable iff (reset)
    detSync[4] && rdFault |=> faultFlags[ffpr_pkg::FLT_SHORT];
  endproperty
  a_shortSet: assert property (p_shortSet) else $error("Short flag lost in read");

  property p_readClear;
    @(posedge clk_sys) disable iff (reset)
    s_faultRead |=> !faultFlags[ffpr_pkg::FLT_OVP];
  endproperty
  a_readClear: assert property (p_readClear) else $error("Fault not cleared");

  property p_readData;
    @(posedge clk_sys) disable iff (reset)
    rdFault |=> (regRdData == $past(faultFlags));
  endproperty
  a_readData: assert property (p_readData) else $error("Fault read data wrong");

  property p_noWrite;
    @(posedge clk_sys) disable iff (reset)
    (regWrite && !regRead && faultSet == 8'h00) |=> $stable(faultFlags);
  endproperty
  a_noWrite: assert property (p_noWrite) else $error("Fault flags changed by write");

  property p_indicatorSkip;
    @(posedge clk_sys) disable iff (reset)
    (modeSetting == ffpr_pkg::MODE_INDICATOR) |=> pulseSkipAllowed && !fixedFreqRun;
  endproperty
  a_indicatorSkip: assert property (p_indicatorSkip) else $error("Indicator not skipping");

  property p_fixFreq;
    @(posedge clk_sys) disable iff (reset)
    (fixFreqEn && fixQualified) |=> fixedFreqRun && !pulseSkipAllowed;
  endproperty
  a_fixFreq: assert property (p_fixFreq) else $error("Fixed frequency not entered");

  property p_skipDefault;
    @(posedge clk_sys) disable iff (reset)
    !fixFreqEn |=> pulseSkipAllowed;
  endproperty
  a_skipDefault: assert property (p_skipDefault) else $error("Skip not allowed");

  property p_cmpOne;
    @(posedge clk_sys) disable iff (reset)
    converterActive |=> (sinkOneHigherFlag == $past(cmpSync[0]));
  endproperty
  a_cmpOne: assert property (p_cmpOne) else $error("Comparator one flag wrong");

  property p_cmpTwoHold;
    @(posedge clk_sys) disable iff (reset)
    !converterActive |=> $stable(sinkTwoHigherFlag);
  endproperty
  a_cmpTwoHold: assert property (p_cmpTwoHold) else $error("Comparator two flag moved");

  property p_uvloSet;
    @(posedge clk_sys) disable iff (reset)
    detSync[0] |=> faultFlags[ffpr_pkg::FLT_UVLO] && !faultFlags[1] && !faultFlags[2];
  endproperty
  a_uvloSet: assert property (p_uvloSet) else $error("Undervoltage flag wrong");

  property p_flagsClear;
    @(posedge clk_sys) disable iff (reset)
    (rdFault && (faultSet == 8'h00)) |=> (faultFlags == ffpr_pkg::FAULT_RESET);
  endproperty
  a_flagsClear: assert property (p_flagsClear) else $error("Fault flags not cleared");

  property p_pwmWrite;
    @(posedge clk_sys) disable iff (reset)
    wrPwm |=> (dutySelect == $past(regWrData[ffpr_pkg::PWM_DUTY_MSB:ffpr_pkg::PWM_DUTY_LSB]));
  endproperty
  a_pwmWrite: assert property (p_pwmWrite) else $error("Duty select not written");

  // Gate lags the mode by the generator flop and the output flop
  property p_gateOff;
    @(posedge clk_sys) disable iff (reset)
    (modeSetting != ffpr_pkg::MODE_INDICATOR) |-> ##2 !sinkPwmGate;
  endproperty
  a_gateOff: assert property (p_gateOff) else $error("Sink gate on outside indicator");

  property p_roBits;
    @(posedge clk_sys) disable iff (reset)
    (wrPwm && !converterActive) |=> $stable({sinkTwoHigherFlag, sinkOneHigherFlag});
  endproperty
  a_roBits: assert property (p_roBits) else $error("Comparator flags moved by write");

endmodule // ffpr_regs

`default_nettype wire

// [ffpr_host_model.sv]
// Purpose: Host side of the register strobe bus for ffpr_regs
// Assumes: Caller enters access just after a rising clock edge
// Notes:   Idle address and data show the inverse of the last value
`default_nettype none

module ffpr_host_model (
  input  wire logic       clk_sys,
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWrData,
  output var  logic       regWrite,
  output var  logic       regRead
);
  timeunit 1ns;
  timeprecision 100ps;

  // Bus idle at time zero
  initial
  begin
    regAddr   = 8'h00;
    regWrData = 8'h00;
    regWrite  = 1'b0;
    regRead   = 1'b0;
  end

  // One strobe cycle; idle lines inverted so a stale value is never taken as held
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    regAddr   = a;
    regWrData = d;
    regWrite  = wr;
    regRead   = !wr;
    @(posedge clk_sys);
    #1;
    regWrite  = 1'b0;
    regRead   = 1'b0;
    regAddr   = ~a;
    regWrData = ~d;
    // One idle edge, so a following call never retoggles a strobe in one step
    @(posedge clk_sys);
    #1;
  endtask
endmodule // ffpr_host_model

`default_nettype wire

// [testbench.sv]
// Purpose: Self-checking bench for the fault and PWM/indicator registers
// Assumes: Read data is sampled on the falling edge after the taking edge
// Notes:   Expected read bytes queue up; a watcher pops one per read
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int FB [6] = '{ffpr_pkg::FLT_UVLO, ffpr_pkg::FLT_TXMASK, ffpr_pkg::FLT_TIMEOUT,
                            ffpr_pkg::FLT_OVERTEMP, ffpr_pkg::FLT_SHORT, ffpr_pkg::FLT_OVP};

  logic        clk_sys;
  logic        reset;
  logic [5:0]  det;
  logic [1:0]  cmp;
  logic        convOn;
  logic [1:0]  mode;
  logic [7:0]  codeOne;
  logic [7:0]  codeTwo;
  logic        boost;
  logic [7:0]  regAddr;
  logic [7:0]  regWrData;
  logic [7:0]  regRdData;
  logic        regWrite;
  logic        regRead;
  logic        gate;
  logic        ffRun;
  logic        skipOk;
  logic        rdTaken;
  logic        ffExp;
  logic [1:0]  cmpExp;
  logic [2:0]  ctlExp;
  logic [7:0]  expQ [$];
  logic [31:0] rnd;
  int          failCount;
  int          nCompared;
  int          cycles;

  ffpr_host_model ffpr_host_model_i (.clk_sys(clk_sys), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead));

  ffpr_regs ffpr_regs_i (.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .overtempDetect(det[3]), .ledShortDetect(det[4]), .ovpDetect(det[5]),
    .uvloDetect(det[0]), .txmaskDetect(det[1]), .timeoutDetect(det[2]),
    .sinkOneHigherCmp(cmp[0]), .sinkTwoHigherCmp(cmp[1]), .converterActive(convOn),
    .modeSetting(mode), .sinkOneCurrentCode(codeOne), .sinkTwoCurrentCode(codeTwo),
    .currentBoost(boost), .sinkPwmGate(gate), .fixedFreqRun(ffRun), .pulseSkipAllowed(skipOk));

  // 50 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    nCompared++;
    if (seen !== exp)
    begin
      failCount++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    ffpr_host_model_i.access(1'b0, a, 8'h00);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ffpr_host_model_i.access(1'b1, a, d);
  endtask

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Read result lands on the taking edge, so the falling edge sees it settled
  always @(posedge clk_sys) rdTaken <= regRead;
  always @(negedge clk_sys)
    if (rdTaken === 1'b1)
    begin
      if (expQ.size() == 0)
        check(16'h0001, 16'h0000, "read with nothing expected");
      else
        check(16'(regRdData), 16'(expQ.pop_front()), "read data");
    end

  // Hang guard; PWM waits dominate the run
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      failCount++;
      end_of_test();
    end
  end

  // Main sequence
  initial
  begin
    int   hi;
    int   k;
    logic last;
    {reset, det, cmp, convOn, mode, codeOne, codeTwo, boost} = {1'b1, 28'h0};
    {cmpExp, ctlExp, failCount, nCompared, cycles} = '0;
    rnd = 32'hFB9A0AAB;
    repeat (6) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    rd(ffpr_pkg::ADDR_FAULT, ffpr_pkg::FAULT_RESET);
    rd(ffpr_pkg::ADDR_PWM, 8'h00);
    check(16'({ffRun, skipOk}), 16'h0001, "reset outputs");
    $display("test reset done");
    // Each fault alone, then cleared by the read
    wr(ffpr_pkg::ADDR_FAULT, 8'hFF);
    rd(ffpr_pkg::ADDR_FAULT, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      det[i] = 1'b1;
      cyc(2);
      det[i] = 1'b0;
      cyc(4);
      rd(ffpr_pkg::ADDR_FAULT, 8'(1 << FB[i]));
      rd(ffpr_pkg::ADDR_FAULT, 8'h00);
    end
    det = 6'h3F;
    cyc(2);
    det = 6'h00;
    cyc(4);
    wr(ffpr_pkg::ADDR_FAULT, 8'h00);
    rd(ffpr_pkg::ADDR_FAULT, 8'hF9);
    // Faults still present while read must survive the clear
    det[5:4] = 2'h3;
    cyc(4);
    rd(ffpr_pkg::ADDR_FAULT, 8'hC0);
    rd(ffpr_pkg::ADDR_FAULT, 8'hC0);
    det[5:4] = 2'h0;
    cyc(4);
    rd(ffpr_pkg::ADDR_FAULT, 8'hC0);
    rd(ffpr_pkg::ADDR_FAULT, 8'h00);
    $display("test faults done");
    // Comparators track only while converting
    convOn = 1'b1;
    for (int i = 1; i < 3; i++)
    begin
      cmp = 2'(i);
      cyc(5);
      cmpExp = 2'(i);
      rd(ffpr_pkg::ADDR_PWM, {3'h0, cmpExp, ctlExp});
    end
    wr(ffpr_pkg::ADDR_PWM, 8'hF8);
    convOn = 1'b0;
    cmp = 2'h1;
    cyc(5);
    rd(ffpr_pkg::ADDR_PWM, {3'h0, cmpExp, ctlExp});
    $display("test comparators done");
    // Random mode, codes near 40h, boost and control byte
    for (int i = 0; i < 40; i++)
    begin
      rnd = lfsr_next(rnd);
      ctlExp = rnd[2:0];
      wr(ffpr_pkg::ADDR_PWM, rnd[7:0]);
      mode = rnd[9:8];
      codeOne = 8'h3F + 8'(rnd[12:10]);
      codeTwo = 8'h3F + 8'(rnd[15:13]);
      boost = &rnd[17:16];
      ffExp = ctlExp[2] && (mode == ffpr_pkg::MODE_FLASH || mode == ffpr_pkg::MODE_ASSIST)
              && codeOne >= ffpr_pkg::CUR_FIXFREQ_MIN && codeTwo >= ffpr_pkg::CUR_FIXFREQ_MIN
              && !boost;
      cyc(3);
      check(16'({ffRun, skipOk}), 16'({ffExp, !ffExp}), "fixed frequency");
      rd(ffpr_pkg::ADDR_PWM, {3'h0, cmpExp, ctlExp});
    end
    $display("test fixed frequency done");
    // Indicator duty: one full period from a rising edge of the gate
    mode = ffpr_pkg::MODE_INDICATOR;
    for (int d = 0; d < 4; d++)
    begin
      ctlExp = 3'(d);
      wr(ffpr_pkg::ADDR_PWM, 8'(d));
      repeat (2)
      begin
        k = 0;
        do
        begin
          last = gate;
          cyc(1);
          k++;
        end while (!(last === 1'b0 && gate === 1'b1) && k < 3400);
      end
      hi = 0;
      repeat (ffpr_pkg::PWM_PERIOD_CYC)
      begin
        last = gate;
        hi += int'(gate === 1'b1);
        cyc(1);
      end
      check(16'(hi), 16'((d + 1) * ffpr_pkg::SLOT_CYC), "gate on time");
      check(16'({last, gate}), 16'h0001, "period restart");
    end
    mode = 2'h0;
    cyc(4);
    check(16'(gate), 16'h0000, "gate off outside indicator");
    $display("test indicator pwm done");
    cyc(3);
    end_of_test();
  end
endmodule // testbench

`default_nettype wire
